// file: shared/ergen_pkg.sv
// Purpose: Shared constants and types for the E1/T1 reference generator
// Assumes: 10 MHz system clock, 2048 kHz reference sampled on it
// Notes: Frame positions count bits from zero at the frame start
package ergen_pkg;
   localparam int REF_KHZ = 2048;
   localparam int T1_KHZ = 1544;
   localparam int ACC_W = 8;
   // Fractional step per reference edge giving the T1 rate
   localparam logic [8:0] ACC_STEP = 9'(T1_KHZ * (1 << ACC_W) / REF_KHZ);
   localparam int SLOT_BITS = 8;
   localparam int E1_SLOTS = 32;
   localparam int T1_CHANNELS = 24;
   localparam int E1_FRAMES = 16;
   localparam int T1_FRAMES = 24;
   localparam logic [7:0] E1_LAST = 8'(E1_SLOTS * SLOT_BITS - 1);
   localparam logic [7:0] T1_LAST = 8'(T1_CHANNELS * SLOT_BITS);
   localparam logic [4:0] E1_FRM_LAST = 5'(E1_FRAMES - 1);
   localparam logic [4:0] T1_FRM_LAST = 5'(T1_FRAMES - 1);
   // Slot zero of even frames: Si then alignment word, sent msb first
   localparam logic [7:0] E1_FAS_BYTE = 8'h9B;
   localparam logic [5:0] T1_FPS = 6'h0B;
   localparam logic [5:0] CRC6_POLY = 6'h03;
   localparam logic [2:0] SA_FIRST_POS = 3'h3;
   localparam logic [2:0] A_BIT_POS = 3'h2;
   localparam logic [2:0] SA_SEL_MAX = 3'h4;
   // Register port
   localparam int ADDR_W = 2;
   localparam int DATA_W = 8;
   localparam logic [1:0] REG_CTRL = 2'h0;
   localparam logic [1:0] REG_SSM = 2'h1;
   localparam logic [1:0] REG_STAT = 2'h2;
   localparam int CTRL_MODE = 0;
   localparam int CTRL_SEL_LSB = 1;
   localparam logic MODE_RST = 1'b0;
   localparam logic [2:0] SEL_RST = 3'h0;
   localparam logic [3:0] SSM_RST = 4'hF;
   localparam int FIFO_DEPTH = 8;

   typedef enum logic [1:0] {SYM_ZERO, SYM_ONE, SYM_VIOL, SYM_BAL} ergen_sym_e;
   typedef enum logic {FR_RESTART, FR_RUN} ergen_fr_e;
   typedef struct packed {
      logic data;
      logic frameStart;
   } ergen_bit_s;

   // One bit step of the x^6+x+1 check sum
   function automatic logic [5:0] crc6_step(input logic [5:0] crc, input logic b);
      logic fb;
      fb = b ^ crc[5];
      return {crc[4:0], 1'b0} ^ (fb ? CRC6_POLY : 6'h00);
   endfunction
endpackage

// file: tb/ergen_line_rx.sv
// Purpose: Far-end receiver model for the coded line and the clock output
// Assumes: Line settles in the same cycle as each rise of the clock output
// Notes: Any mark decodes as one; substitutions are only counted
`timescale 1ns/100ps
`default_nettype none
module ergen_line_rx (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clkOut,
   input wire logic linePos,
   input wire logic lineNeg,
   input wire logic frameMark,
   output logic [8:0] lastLen,
   output logic [7:0] lastHead,
   output logic [7:0] prevHead,
   output logic [7:0] tailOnes,
   output logic [23:0] fBits,
   output logic [15:0] frameCnt,
   output logic [15:0] clkRises,
   output logic [15:0] violCnt,
   output logic bothSeen
);
   logic clkPrev, tick, lastPol, anyMark;
   logic [8:0] bitCnt;
   logic [7:0] head, ones;
   wire logic markNow = linePos | lineNeg;
   // Sample a cycle after each clock rise, so the line has settled
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         {clkPrev, tick, lastPol, anyMark, bothSeen} <= '0;
         {bitCnt, head, ones, lastLen, lastHead, prevHead, tailOnes} <= '0;
         {fBits, frameCnt, clkRises, violCnt} <= '0;
      end else begin
         clkPrev <= clkOut;
         tick <= clkOut & ~clkPrev;
         if (clkOut & ~clkPrev) clkRises <= clkRises + 16'h0001;
         if (linePos & lineNeg) bothSeen <= 1'b1;
         if (tick && frameMark) begin
            lastLen <= bitCnt;
            prevHead <= lastHead;
            lastHead <= head;
            tailOnes <= ones;
            fBits <= {fBits[22:0], markNow};
            frameCnt <= frameCnt + 16'h0001;
            bitCnt <= 9'h001;
            head <= {7'h00, markNow};
            ones <= 8'h00;
         end else if (tick) begin
            bitCnt <= bitCnt + 9'h001;
            if (bitCnt < 9'h008) head <= {head[6:0], markNow};
            else ones <= ones + {7'h00, markNow};
         end
         // Same polarity twice in a row is a bipolar violation
         if (tick && markNow) begin
            if (anyMark && linePos == lastPol) violCnt <= violCnt + 16'h0001;
            lastPol <= linePos;
            anyMark <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// file: tb/ergen_top_bench.sv
// Purpose: Self-checking bench for the reference output generator
// Assumes: Reference made here from the 10 MHz clock by a phase step
// Notes: Clock rate is judged over 512 reference periods, one rise slack
`timescale 1ns/100ps
`default_nettype none
`define CHECK(nm, exp, got) \
   begin \
      checked++; \
      if ((got) !== (exp)) begin \
         miscompares++; \
         $display("BAD %s expected %0h seen %0h", nm, exp, got); \
      end \
   end
module ergen_top_bench;
   import ergen_pkg::*;
   logic ref_clk = 1'b0, rst = 1'b1, ref2048 = 1'b0, regWr = 1'b0, regRd = 1'b0;
   logic [1:0] regAddr = 2'h0;
   logic [7:0] regWData = 8'h00, regRDataQ, rd;
   logic clkOutQ, linePosQ, lineNegQ, frameMarkQ, ledE1Q, ledT1Q, bothSeen;
   logic [8:0] lastLen;
   logic [7:0] lastHead, prevHead, tailOnes;
   logic [23:0] fBits;
   logic [15:0] frameCnt, clkRises, violCnt;
   int miscompares = 0, checked = 0, refAcc = 0, refRises = 0;
   ergen_top dut (.ref_clk(ref_clk), .rst(rst), .ref2048(ref2048), .regAddr(regAddr),
      .regWData(regWData), .regWr(regWr), .regRd(regRd), .regRDataQ(regRDataQ),
      .clkOutQ(clkOutQ), .linePosQ(linePosQ), .lineNegQ(lineNegQ),
      .frameMarkQ(frameMarkQ), .ledE1Q(ledE1Q), .ledT1Q(ledT1Q));
   ergen_line_rx rx (.ref_clk(ref_clk), .rst(rst), .clkOut(clkOutQ), .linePos(linePosQ),
      .lineNeg(lineNegQ), .frameMark(frameMarkQ), .lastLen(lastLen), .lastHead(lastHead),
      .prevHead(prevHead), .tailOnes(tailOnes), .fBits(fBits), .frameCnt(frameCnt),
      .clkRises(clkRises), .violCnt(violCnt), .bothSeen(bothSeen));
   always #50 ref_clk = ~ref_clk;
   // Phase step makes 2048 kHz from 10 MHz, edges jitter by one cycle
   always @(posedge ref_clk) begin
      if (refAcc + 2 * REF_KHZ >= 10000) begin
         refAcc <= refAcc + 2 * REF_KHZ - 10000;
         ref2048 <= ~ref2048;
         if (!ref2048) refRises <= refRises + 1;
      end else begin
         refAcc <= refAcc + 2 * REF_KHZ;
      end
   end
   task automatic end_sim();
      $display("Counts: checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic regWrite(input logic [1:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      regWData <= d;
      regWr <= 1'b1;
      @(posedge ref_clk);
      regWr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic chk(input logic [1:0] a, input logic [7:0] e, input string nm);
      @(posedge ref_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge ref_clk);
      regRd <= 1'b0;
      #1 rd = regRDataQ;
      `CHECK(nm, e, rd)
   endtask
   task automatic waitFrames(input int n);
      int f0, k;
      f0 = int'(frameCnt);
      k = 0;
      while (int'(frameCnt) - f0 < n && k < 2000 * n) begin
         @(posedge ref_clk);
         k++;
      end
      if (k >= 2000 * n) begin
         miscompares++;
         $display("BAD frame wait expected %0d seen %0d", n, int'(frameCnt) - f0);
         end_sim();
      end
   endtask
   // Lets a restart settle, then judges two whole frames
   task automatic frameCheck(input logic [8:0] len, input logic [7:0] tail,
      input logic [7:0] odd);
      logic [15:0] v0;
      waitFrames(3);
      v0 = violCnt;
      waitFrames(2);
      `CHECK("frame length", len, lastLen)
      `CHECK("payload ones", tail, tailOnes)
      `CHECK("violations", v0, violCnt)
      if (odd != 8'h00) begin
         `CHECK("slot zero", 1'b1, ({lastHead, prevHead} == {E1_FAS_BYTE, odd}) ||
            ({prevHead, lastHead} == {E1_FAS_BYTE, odd}))
      end
   endtask
   task automatic measureClk(input int e);
      int r0, c0, k, d;
      r0 = refRises;
      c0 = int'(clkRises);
      k = 0;
      while (refRises - r0 < 512 && k < 3000) begin
         @(posedge ref_clk);
         k++;
      end
      if (k >= 3000) begin
         miscompares++;
         $display("BAD clock wait expected %0d seen %0d", 512, refRises - r0);
         end_sim();
      end
      d = int'(clkRises) - c0;
      `CHECK("clock rises", 1'b1, (d >= e - 1 && d <= e + 1))
   endtask
   // Superframe phase is unknown, so every phase and rotation is tried
   function automatic logic esfOk(input logic [23:0] f);
      logic [5:0] v;
      logic ok, good;
      good = 1'b0;
      for (int s = 0; s < 4; s++) begin
         v = '0;
         ok = 1'b1;
         for (int i = 0; i < 24; i++) begin
            if ((i + s) % 2 == 0 && f[23 - i] !== 1'b1) ok = 1'b0;
            if ((i + s) % 4 == 3) v = {v[4:0], f[23 - i]};
         end
         for (int r = 0; r < 6; r++) begin
            if (ok && 6'({v, v} >> r) == 6'b001011) good = 1'b1;
         end
      end
      return good;
   endfunction
   task automatic resetDut();
      @(posedge ref_clk);
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      #1 `CHECK("led e1", 1'b1, ledE1Q)
      `CHECK("led t1", 1'b0, ledT1Q)
      chk(REG_CTRL, 8'h00, "ctrl reset");
      chk(REG_SSM, 8'h0F, "ssm reset");
      chk(REG_STAT, 8'h40, "stat after reset");
   endtask
   // Main sequence
   initial begin
      resetDut();
      chk(2'h3, 8'h00, "unmapped");
      regWrite(2'h3, 8'hFF);
      chk(2'h3, 8'h00, "unmapped write");
      frameCheck(9'd256, 8'd248, 8'hDF);
      measureClk(512);
      for (int i = 0; i <= 4; i++) begin
         regWrite(REG_CTRL, 8'(i << 1));
         chk(REG_CTRL, 8'(i << 1), "spare select");
      end
      regWrite(REG_CTRL, 8'h0A);
      chk(REG_CTRL, 8'h08, "select kept");
      regWrite(REG_SSM, 8'h00);
      chk(REG_SSM, 8'h00, "ssm");
      regWrite(REG_CTRL, 8'h04);
      frameCheck(9'd256, 8'd248, 8'hDB);
      regWrite(REG_CTRL, 8'h01);
      @(posedge ref_clk);
      #1 `CHECK("led t1 early", 1'b0, ledT1Q)
      @(posedge ref_clk);
      #1 `CHECK("led t1", 1'b1, ledT1Q)
      `CHECK("led e1", 1'b0, ledE1Q)
      chk(REG_CTRL, 8'h01, "ctrl t1");
      frameCheck(9'd193, 8'd185, 8'h00);
      measureClk(386);
      waitFrames(22);
      `CHECK("superframe", 1'b1, esfOk(fBits))
      resetDut();
      frameCheck(9'd256, 8'd248, 8'hDF);
      measureClk(512);
      `CHECK("both rails", 1'b0, bothSeen)
      end_sim();
   end
endmodule
`default_nettype wire

// file: verilog/ergen_fifo.sv
// Purpose: Small bit FIFO between framer and line coder
// Assumes: Single clock, flush empties it in one cycle
// Notes: Pointers carry one extra bit so full and empty are exact
`timescale 1ns/100ps
`default_nettype none
module ergen_fifo #(
   parameter int WIDTH = 2,
   parameter int DEPTH = 8
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic flush,
   input wire logic [WIDTH-1:0] inData,
   input wire logic inValid,
   output logic inReady,
   output logic [WIDTH-1:0] outData,
   output logic outValid,
   input wire logic outReady
);
   import ergen_pkg::*;
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] memQ [DEPTH];
   logic [PW:0] wrPtrQ;
   logic [PW:0] rdPtrQ;
   wire push = inValid && inReady;
   wire pop = outValid && outReady;
   wire [PW:0] used = wrPtrQ - rdPtrQ;

   // Status and head word
   assign inReady = used != (PW + 1)'(DEPTH);
   assign outValid = used != '0;
   assign outData = memQ[rdPtrQ[PW-1:0]];

   // Pointers; flush drops whatever is queued
   always_ff @(posedge ref_clk) begin
      if (rst || flush) begin
         wrPtrQ <= '0;
         rdPtrQ <= '0;
      end else begin
         wrPtrQ <= wrPtrQ + (PW + 1)'(push);
         rdPtrQ <= rdPtrQ + (PW + 1)'(pop);
      end
   end

   // Storage needs no reset
   always_ff @(posedge ref_clk) begin
      if (push) begin
         memQ[wrPtrQ[PW-1:0]] <= inData;
      end
   end
endmodule
`default_nettype wire

// file: verilog/ergen_line_coder.sv
// Purpose: HDB3 or B8ZS coder with dual-rail line outputs
// Assumes: One bit enters and one symbol leaves per bit tick
// Notes: Delay line of eight symbols; E1 taps the fourth stage
`timescale 1ns/100ps
`default_nettype none
module ergen_line_coder (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic flush,
   input wire logic t1Mode,
   input wire logic bitTick,
   input wire ergen_pkg::ergen_bit_s inData,
   input wire logic inValid,
   output logic inReady,
   output logic linePosQ,
   output logic lineNegQ,
   output logic frameMarkQ
);
   import ergen_pkg::*;
   ergen_sym_e symQ [8];
   ergen_sym_e symD [8];
   logic [7:0] markQ;
   logic [7:0] isZero;
   logic lastPolQ;
   logic parQ;
   logic [3:0] zeroRunQ;

   // Output tap and pulse bookkeeping
   wire [2:0] tap = t1Mode ? 3'h7 : 3'h3;
   wire ergen_sym_e outSym = symQ[tap];
   wire outViol = outSym == SYM_VIOL;
   wire outPulse = (outSym == SYM_ONE) || (outSym == SYM_BAL);
   wire parAfter = outViol ? 1'b0 : parQ ^ outPulse;
   wire pulsePol = outViol ? lastPolQ : !lastPolQ;
   wire ergen_sym_e newSym = (inValid && inData.data) ? SYM_ONE : SYM_ZERO;
   wire run4 = (newSym == SYM_ZERO) && (&isZero[2:0]);
   wire run8 = (newSym == SYM_ZERO) && (&isZero[6:0]);
   assign inReady = bitTick;

   // Shift plus zero-run substitution
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         isZero[i] = symQ[i] == SYM_ZERO;
      end
      for (int i = 7; i > 0; i--) begin
         symD[i] = symQ[i-1];
      end
      symD[0] = newSym;
      if (!t1Mode && run4) begin
         // Odd pulse count since last violation gives 000V, even gives B00V
         symD[3] = parAfter ? SYM_ZERO : SYM_BAL;
         symD[0] = SYM_VIOL;
      end else if (t1Mode && run8) begin
         symD[4] = SYM_VIOL;
         symD[3] = SYM_BAL;
         symD[1] = SYM_VIOL;
         symD[0] = SYM_BAL;
      end
   end

   // Line state; idle marks fill the line until frames arrive
   always_ff @(posedge ref_clk) begin
      if (rst || flush) begin
         for (int i = 0; i < 8; i++) begin
            symQ[i] <= SYM_ONE;
         end
         markQ <= 8'h00;
         lastPolQ <= 1'b0;
         parQ <= 1'b0;
         linePosQ <= 1'b0;
         lineNegQ <= 1'b0;
         frameMarkQ <= 1'b0;
      end else if (bitTick) begin
         symQ <= symD;
         markQ <= {markQ[6:0], inValid && inData.frameStart};
         parQ <= parAfter;
         lastPolQ <= (outPulse || outViol) ? pulsePol : lastPolQ;
         linePosQ <= (outPulse || outViol) && pulsePol;
         lineNegQ <= (outPulse || outViol) && !pulsePol;
         frameMarkQ <= markQ[tap];
      end
   end

   // Checking aid: length of the current run of zero symbols
   always_ff @(posedge ref_clk) begin
      if (rst || flush) begin
         zeroRunQ <= 4'h0;
      end else if (bitTick) begin
         zeroRunQ <= (outPulse || outViol) ? 4'h0 : zeroRunQ + 4'h1;
      end
   end

   property p_zero_run;
      @(posedge ref_clk) disable iff (rst || flush)
      zeroRunQ <= (t1Mode ? 4'h7 : 4'h3);
   endproperty
   a_zero_run: assert property (p_zero_run) else $error("zero run too long");

   property p_rails;
      @(posedge ref_clk) disable iff (rst)
      !(linePosQ && lineNegQ);
   endproperty
   a_rails: assert property (p_rails) else $error("both rails high");
endmodule
`default_nettype wire

// file: verilog/ergen_top.sv
// Purpose: E1/T1 reference clock and framed all-ones generator
// Assumes: ref2048 and register port are synchronous to ref_clk
// Notes: All rates come from reference edges, no other timebase
// Operation
// - Every output rate is derived from the one 2048 kHz reference input.
// - Clock output runs 1544 kHz in T1 and 2048 kHz in E1.
// - Framed payload bytes are all ones, nothing else inserted.
// - Framed bits leave at 1544 kbit/s in T1, 2048 kbit/s in E1.
// - T1 frames are grouped as an extended superframe.
// - Line code is HDB3 in E1 and B8ZS in T1.
// - One mode selection governs all outputs together.
// - Mode may change while running; a change restarts the stream.
// - Indicator outputs show the selected mode.
// - Unused spare bits Sa4 to Sa8 are sent as one.
// - Status message spare bit is selectable, Sa4 after reset.
// - E1 frame has 32 slots of 64 kbit/s, slot zero reserved.
// - T1 frame holds 24 channels.
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module ergen_top (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ref2048,
   input wire logic [ergen_pkg::ADDR_W-1:0] regAddr,
   input wire logic [ergen_pkg::DATA_W-1:0] regWData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [ergen_pkg::DATA_W-1:0] regRDataQ,
   output logic clkOutQ,
   output logic linePosQ,
   output logic lineNegQ,
   output logic frameMarkQ,
   output logic ledE1Q,
   output logic ledT1Q
);
   import ergen_pkg::*;

   logic refQ;
   logic [ACC_W-1:0] accQ;
   logic ctrlT1Q;
   logic modeQ;
   logic restartQ;
   logic [2:0] selQ;
   logic [3:0] ssmCodeQ;
   ergen_fr_e frStateQ;
   logic [7:0] posQ;
   logic [4:0] frmQ;
   logic [5:0] crcQ;
   logic [5:0] crcSentQ;
   ergen_bit_s wrBit;
   ergen_bit_s rdBit;
   logic fifoInReady;
   logic fifoOutValid;
   logic coderReady;

   // Reference edges and fractional divider for the T1 rate
   wire refEdge = ref2048 ^ refQ;
   wire [ACC_W:0] accSum = {1'b0, accQ} + ACC_STEP;
   wire toggle = refEdge && (modeQ ? accSum[ACC_W] : 1'b1);
   wire bitTick = toggle && !clkOutQ;

   // No reset on the sampled level, so a release never fakes a reference edge
   always_ff @(posedge ref_clk) begin
      refQ <= ref2048;
   end

   // Clock output toggles on selected edges; divider restarts with mode
   always_ff @(posedge ref_clk) begin
      if (rst || restartQ) begin
         accQ <= '0;
      end else if (refEdge) begin
         accQ <= accSum[ACC_W-1:0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         clkOutQ <= 1'b0;
      end else begin
         clkOutQ <= clkOutQ ^ toggle;
      end
   end

   // Register decode
   wire ctrlWr = regWr && (regAddr == REG_CTRL);
   wire ssmWr = regWr && (regAddr == REG_SSM);
   wire [2:0] selWr = regWData[CTRL_SEL_LSB +: 3];
   wire [DATA_W-1:0] rdMux =
      (regAddr == REG_CTRL) ? {4'h0, selQ, ctrlT1Q} :
      (regAddr == REG_SSM) ? {4'h0, ssmCodeQ} :
      (regAddr == REG_STAT) ? {1'b0, fifoOutValid, frmQ, modeQ} : 8'h00;

   // Writes; a selection beyond Sa8 is ignored to keep the old choice
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrlT1Q <= MODE_RST;
         selQ <= SEL_RST;
         ssmCodeQ <= SSM_RST;
      end else begin
         if (ctrlWr) begin
            ctrlT1Q <= regWData[CTRL_MODE];
            selQ <= (selWr <= SA_SEL_MAX) ? selWr : selQ;
         end
         if (ssmWr) begin
            ssmCodeQ <= regWData[3:0];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         regRDataQ <= '0;
      end else begin
         regRDataQ <= regRd ? rdMux : '0;
      end
   end

   // One active mode for every output; a change restarts the stream
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         modeQ <= MODE_RST;
         restartQ <= 1'b1;
         ledE1Q <= 1'b1;
         ledT1Q <= 1'b0;
      end else begin
         modeQ <= ctrlT1Q;
         restartQ <= ctrlT1Q != modeQ;
         ledE1Q <= !modeQ;
         ledT1Q <= modeQ;
      end
   end

   property p_led_onehot;
      @(posedge ref_clk) disable iff (rst)
      ledE1Q != ledT1Q;
   endproperty
   a_led_onehot: assert property (p_led_onehot) else $error("mode indicators not one-hot");

   // E1 slot zero content: alignment word or spare bits
   wire [2:0] bitN = posQ[2:0];
   wire [2:0] saIdx = bitN - SA_FIRST_POS;
   wire ssmBit = ssmCodeQ[2'h3 - frmQ[2:1]];
   wire saBit = (saIdx == selQ) ? ssmBit : 1'b1;
   wire fasBit = E1_FAS_BYTE[3'h7 - bitN];
   wire nfasBit = (bitN < SA_FIRST_POS) ? (bitN != A_BIT_POS) : saBit;
   wire e1Bit = (posQ[7:3] != 5'h00) ? 1'b1 : (frmQ[0] ? nfasBit : fasBit);

   // T1 framing bit: pattern, check sum or idle data link
   wire [2:0] sfIdx = frmQ[4:2];
   wire fBit = (frmQ[1:0] == 2'h3) ? T1_FPS[3'h5 - sfIdx] :
      (frmQ[1:0] == 2'h1) ? crcSentQ[3'h5 - sfIdx] : 1'b1;
   wire t1Bit = (posQ == 8'h00) ? fBit : 1'b1;

   wire frmBit = modeQ ? t1Bit : e1Bit;
   wire [7:0] posLast = modeQ ? T1_LAST : E1_LAST;
   wire [4:0] frmLast = modeQ ? T1_FRM_LAST : E1_FRM_LAST;
   wire posWrap = posQ == posLast;
   wire sfEnd = posWrap && (frmQ == frmLast);
   wire fifoWr = (frStateQ == FR_RUN) && fifoInReady;
   wire [5:0] crcNext = crc6_step(crcQ, (posQ == 8'h00) ? 1'b1 : frmBit);
   assign wrBit.data = frmBit;
   assign wrBit.frameStart = posQ == 8'h00;

   // Framer walks bit, frame and multiframe counters as the FIFO accepts
   always_ff @(posedge ref_clk) begin
      if (rst || restartQ) begin
         frStateQ <= FR_RESTART;
         posQ <= 8'h00;
         frmQ <= 5'h00;
         crcQ <= 6'h00;
         crcSentQ <= 6'h00;
      end else begin
         case (frStateQ)
            FR_RESTART: begin
               frStateQ <= FR_RUN;
            end
            FR_RUN: begin
               if (fifoWr) begin
                  posQ <= posWrap ? 8'h00 : posQ + 8'h01;
                  if (posWrap) begin
                     frmQ <= (frmQ == frmLast) ? 5'h00 : frmQ + 5'h01;
                  end
                  crcQ <= sfEnd ? 6'h00 : crcNext;
                  crcSentQ <= (sfEnd && modeQ) ? crcNext : crcSentQ;
               end
            end
            default: begin
               frStateQ <= FR_RESTART;
            end
         endcase
      end
   end

   // Bits wait here for the line rate; a full FIFO stalls the framer
   ergen_fifo #(
      .WIDTH($bits(ergen_bit_s)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .ref_clk(ref_clk),
      .rst(rst),
      .flush(restartQ),
      .inData(wrBit),
      .inValid(frStateQ == FR_RUN),
      .inReady(fifoInReady),
      .outData(rdBit),
      .outValid(fifoOutValid),
      .outReady(coderReady)
   );

   ergen_line_coder u_coder (
      .ref_clk(ref_clk),
      .rst(rst),
      .flush(restartQ),
      .t1Mode(modeQ),
      .bitTick(bitTick),
      .inData(rdBit),
      .inValid(fifoOutValid),
      .inReady(coderReady),
      .linePosQ(linePosQ),
      .lineNegQ(lineNegQ),
      .frameMarkQ(frameMarkQ)
   );

   // Checking aid: clock toggles over 256 reference edges in T1
   logic [7:0] edgeCntQ;
   logic [8:0] togCntQ;
   always_ff @(posedge ref_clk) begin
      if (rst || restartQ) begin
         edgeCntQ <= 8'h00;
         togCntQ <= 9'h000;
      end else if (refEdge) begin
         edgeCntQ <= edgeCntQ + 8'h01;
         togCntQ <= (edgeCntQ == 8'hFF) ? 9'h000 : togCntQ + 9'(toggle);
      end
   end

   property p_t1_rate;
      @(posedge ref_clk) disable iff (rst || restartQ)
      (modeQ && refEdge && edgeCntQ == 8'hFF) |-> (togCntQ + 9'(toggle) == ACC_STEP);
   endproperty
   a_t1_rate: assert property (p_t1_rate) else $error("T1 clock rate wrong");

   property p_e1_follow;
      @(posedge ref_clk) disable iff (rst)
      (!modeQ && refEdge) |=> (clkOutQ != $past(clkOutQ));
   endproperty
   a_e1_follow: assert property (p_e1_follow) else $error("E1 clock missed edge");

   property p_bit_tick;
      @(posedge ref_clk) disable iff (rst)
      bitTick |=> $rose(clkOutQ) ##1 !bitTick;
   endproperty
   a_bit_tick: assert property (p_bit_tick) else $error("bit tick off clock");

   sequence s_mode_write;
      ctrlWr && (regWData[CTRL_MODE] != ctrlT1Q) && (ctrlT1Q == modeQ);
   endsequence
   property p_mode_switch;
      @(posedge ref_clk) disable iff (rst)
      s_mode_write ##1 !ctrlWr |-> ##1 (restartQ && modeQ == $past(regWData[CTRL_MODE], 2))
         ##1 (frStateQ == FR_RESTART);
   endproperty
   a_mode_switch: assert property (p_mode_switch) else $error("mode change not applied");

   sequence s_quiet_ctrl;
      ctrlWr ##1 !ctrlWr [*2];
   endsequence
   property p_leds;
      @(posedge ref_clk) disable iff (rst)
      s_quiet_ctrl |-> ##1 (ledT1Q == $past(regWData[CTRL_MODE], 3) && ledE1Q == !ledT1Q);
   endproperty
   a_leds: assert property (p_leds) else $error("mode indicator wrong");

   property p_reset_start;
      @(posedge ref_clk) disable iff (rst)
      $fell(rst) |-> (frStateQ == FR_RESTART && !modeQ && selQ == SEL_RST)
         ##2 (frStateQ == FR_RUN);
   endproperty
   a_reset_start: assert property (p_reset_start) else $error("bad reset start");

   property p_payload_ones;
      @(posedge ref_clk) disable iff (rst)
      (fifoWr && (modeQ ? posQ != 8'h00 : posQ[7:3] != 5'h00)) |-> wrBit.data;
   endproperty
   a_payload_ones: assert property (p_payload_ones) else $error("payload not ones");

   property p_frame_len;
      @(posedge ref_clk) disable iff (rst || restartQ)
      (fifoWr && posQ == posLast) |=> (posQ == 8'h00 && wrBit.frameStart);
   endproperty
   a_frame_len: assert property (p_frame_len) else $error("frame length wrong");

   property p_superframe;
      @(posedge ref_clk) disable iff (rst || restartQ)
      (frmQ <= frmLast) && (modeQ ? posQ <= T1_LAST : 1'b1);
   endproperty
   a_superframe: assert property (p_superframe) else $error("counter overrun");

   property p_spare_ones;
      @(posedge ref_clk) disable iff (rst)
      (fifoWr && !modeQ && frmQ[0] && posQ[7:3] == 5'h00 && bitN >= SA_FIRST_POS
         && saIdx != selQ) |-> wrBit.data;
   endproperty
   a_spare_ones: assert property (p_spare_ones) else $error("spare bit not one");
endmodule
`default_nettype wire
